// *** logic/rpg_defines.svh ***
// constants for reset, power gating and slave port mode selection
`ifndef RPG_DEFINES_SVH
`define RPG_DEFINES_SVH

// pll configuration register addresses
`define RPG_PLL_FB_ADDR     16'hF000
`define RPG_PLL_PRE_ADDR    16'hF001
`define RPG_PLL_SRC_ADDR    16'hF002
`define RPG_PLL_EN_ADDR     16'hF003
`define RPG_PLL_LOCK_ADDR   16'hF004
// power gating register addresses
`define RPG_PWR0_ADDR       16'hF050
`define RPG_PWR1_ADDR       16'hF051

// reset values
`define RPG_PLL_FB_RST      16'h0000
`define RPG_PLL_PRE_RST     16'h0000
`define RPG_PLL_SRC_RST     16'h0000
`define RPG_PLL_EN_RST      1'h0
`define RPG_PWR0_RST        7'h7F
`define RPG_PWR1_RST        4'hF

// field widths of the power registers
`define RPG_PWR0_W          7
`define RPG_PWR1_W          4
`define RPG_BLK_W           11
// power register 0 fields: [2:0] clock generators, [3] serial in,
// [4] serial out, [5] converter bank 0, [6] converter bank 1
`define RPG_PWR0_SRC_LO     5
// power register 1 fields: [0] pdm, [1] spdif rx, [2] spdif tx,
// [3] aux adc

// number of slave select pulses that select spi
`define RPG_SPI_PULSES      2'h3

`endif

// *** logic/rpg_pkg.sv ***
// types shared by the reset and power gating block
package rpg_pkg;

  // 16-bit control word
  typedef logic [15:0] word_t;

  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM
  } acc_state_t;

endpackage : rpg_pkg

// *** logic/rpg_ctl_if.sv ***
// signals carried between the top and its two helper modules
`timescale 1ns/10ps
interface rpg_ctl_if;
  logic               spi_mode_m;  // spi selected, master clock domain
  rpg_pkg::word_t     addr;        // access address
  logic               locked;      // pll lock, system domain
  logic               sel_pll;     // pll configuration register
  logic               sel_pwr0;    // power register 0
  logic               sel_pwr1;    // power register 1
  logic               sel_mem;     // forwarded to core / memory
  logic               allow;       // address open at this time

  modport det  (output spi_mode_m);
  modport gate (input addr, input locked,
                output sel_pll, output sel_pwr0, output sel_pwr1,
                output sel_mem, output allow);
  modport top  (input spi_mode_m, output addr, output locked,
                input sel_pll, input sel_pwr0, input sel_pwr1,
                input sel_mem, input allow);
endinterface : rpg_ctl_if

// *** logic/port_mode_detect.sv ***
// slave select pulse counter on the master clock
`timescale 1ns/10ps
`include "rpg_defines.svh"
module port_mode_detect (
  // master clock domain
  input  wire logic master_clock_input,
  input  wire logic arst_n,
  // slave select pin, raw
  input  wire logic ss_pin,
  // mode to the top
  rpg_ctl_if.det    ctl
);
  logic       ss_s1_q;   // first sync stage
  logic       ss_s2_q;   // second sync stage
  logic       ss_s3_q;   // previous synced level
  logic [1:0] cnt_q;     // qualified pulses so far
  logic       spi_q;     // spi selected

  // two-stage synchroniser plus history
  always_ff @(posedge master_clock_input or negedge arst_n) begin
    if (!arst_n) begin
      ss_s1_q <= 1'h1;
      ss_s2_q <= 1'h1;
      ss_s3_q <= 1'h1;
    end else begin
      ss_s1_q <= ss_pin;
      ss_s2_q <= ss_s1_q;
      ss_s3_q <= ss_s2_q;
    end
  end

  // a rise after a low sample closes a pulse of one period or more
  always_ff @(posedge master_clock_input or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
      spi_q <= 1'h0;
    end else if (!spi_q && ss_s2_q && !ss_s3_q) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q + 2'h1 == `RPG_SPI_PULSES)
        spi_q <= 1'h1;
    end
  end

  assign ctl.spi_mode_m = spi_q;

  spi_after_three_a: assert property (
    @(posedge master_clock_input) disable iff (!arst_n)
    $rose(spi_q) |-> $past(cnt_q) == 2'h2)
    else $error("spi mode without three pulses");
  mode_sticks_a: assert property (
    @(posedge master_clock_input) disable iff (!arst_n)
    spi_q |=> spi_q)
    else $error("spi mode dropped without reset");
  spi_switch_c: cover property (
    @(posedge master_clock_input) disable iff (!arst_n) $rose(spi_q));
endmodule : port_mode_detect

// *** logic/access_gate.sv ***
// decodes an access address and decides if it is open now
`timescale 1ns/10ps
`include "rpg_defines.svh"
module access_gate (
  rpg_ctl_if.gate ctl
);
  // address decode
  always_comb begin
    ctl.sel_pll  = 1'h0;
    ctl.sel_pwr0 = 1'h0;
    ctl.sel_pwr1 = 1'h0;
    ctl.sel_mem  = 1'h0;
    if (ctl.addr >= `RPG_PLL_FB_ADDR && ctl.addr <= `RPG_PLL_LOCK_ADDR) begin
      ctl.sel_pll = 1'h1;
    end else if (ctl.addr == `RPG_PWR0_ADDR) begin
      ctl.sel_pwr0 = 1'h1;
    end else if (ctl.addr == `RPG_PWR1_ADDR) begin
      ctl.sel_pwr1 = 1'h1;
    end else begin
      ctl.sel_mem = 1'h1;
    end
  end

  // pll registers always open, the rest only after lock
  assign ctl.allow = ctl.sel_pll | ctl.locked;

  blocked_before_lock_a: assert property (
    @(ctl.addr) !ctl.locked && (ctl.addr < `RPG_PLL_FB_ADDR ||
      ctl.addr > `RPG_PLL_LOCK_ADDR) |-> !ctl.allow)
    else $error("access allowed before lock");
endmodule : access_gate

// *** logic/reset_power_gating_port_mode.sv ***
// reset sequencing, block clock gates and slave port mode control
`timescale 1ns/10ps
`include "rpg_defines.svh"
module reset_power_gating_port_mode (
  // system clock and reset pin
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  // master clock (link domain)
  input  wire logic                   master_clock_input,
  // slave port pins
  input  wire logic                   dev_address_bit1_pin,
  input  wire logic                   dev_address_bit2_pin,
  // pll status
  input  wire logic                   pll_lock_in,
  // decoded slave port access
  input  wire logic                   acc_req,
  input  wire logic                   acc_write,
  input  wire rpg_pkg::word_t         acc_addr,
  input  wire rpg_pkg::word_t         acc_wdata,
  output      logic                   acc_ack,
  output      logic                   acc_refused,
  output      rpg_pkg::word_t         acc_rdata,
  // core / memory side
  output      logic                   mem_req,
  output      logic                   mem_write,
  output      rpg_pkg::word_t         mem_addr,
  output      rpg_pkg::word_t         mem_wdata,
  input  wire rpg_pkg::word_t         mem_rdata,
  // block clock enables
  output      logic [`RPG_BLK_W-1:0]  blk_en,
  // pll configuration
  output      rpg_pkg::word_t         pll_fb_div,
  output      rpg_pkg::word_t         pll_pre_div,
  output      rpg_pkg::word_t         pll_src,
  output      logic                   pll_enable,
  // port mode and status
  output      logic                   spi_mode,
  output      logic [1:0]             i2c_addr_bits,
  output      logic                   ready
);

  rpg_ctl_if ctl ();

  // mode counter on the master clock
  port_mode_detect u_detect (
    .master_clock_input (master_clock_input),
    .arst_n             (arst_n),
    .ss_pin             (dev_address_bit1_pin),
    .ctl                (ctl)
  );

  // address gate
  access_gate u_gate (
    .ctl (ctl)
  );

  // synchroniser stages
  logic rdy_s1_q;    // reset release, stage 1
  logic rdy_q;       // reset release, stage 2
  logic lk_s1_q;     // pll lock, stage 1
  logic lk_q;        // pll lock, stage 2
  logic spi_s1_q;    // spi mode, stage 1
  logic spi_q;       // spi mode, stage 2
  logic a1_s1_q;     // address bit 1 pin, stage 1
  logic a1_q;        // address bit 1 pin, stage 2
  logic a2_s1_q;     // address bit 2 pin, stage 1
  logic a2_q;        // address bit 2 pin, stage 2

  // registers
  rpg_pkg::word_t             pll_fb_q;    // feedback divider
  rpg_pkg::word_t             pll_pre_q;   // prescale divider
  rpg_pkg::word_t             pll_src_q;   // clock source
  logic                       pll_en_q;    // pll enable
  logic [`RPG_PWR0_W-1:0]     pwr0_q;      // power register 0
  logic [`RPG_PWR1_W-1:0]     pwr1_q;      // power register 1
  logic [`RPG_BLK_W-1:0]      blk_en_q;    // gated enables
  logic [1:0]                 i2c_bits_q;  // device address bits

  // access sequencer
  rpg_pkg::acc_state_t        st_q;        // sequencer state
  logic                       ack_q;       // answer strobe
  logic                       ref_q;       // refused flag
  rpg_pkg::word_t             rdata_q;     // answer data
  logic                       mreq_q;      // memory request
  logic                       mwr_q;       // memory write
  rpg_pkg::word_t             maddr_q;     // memory address
  rpg_pkg::word_t             mwdata_q;    // memory write data
  logic                       take;        // request taken now
  logic                       wr_ok;       // register write allowed
  rpg_pkg::word_t             rd_mux;      // register read value

  assign ctl.addr   = acc_addr;
  assign ctl.locked = lk_q;
  assign take       = acc_req && st_q == rpg_pkg::ST_IDLE && rdy_q;
  assign wr_ok      = take && acc_write && ctl.allow;

  // reset release: no pulse is needed, power-on reset starts it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdy_s1_q <= 1'h0;
      rdy_q    <= 1'h0;
    end else begin
      rdy_s1_q <= 1'h1;
      rdy_q    <= rdy_s1_q;
    end
  end

  // pll lock, spi mode and pin synchronisers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lk_s1_q  <= 1'h0;
      lk_q     <= 1'h0;
      spi_s1_q <= 1'h0;
      spi_q    <= 1'h0;
      a1_s1_q  <= 1'h0;
      a1_q     <= 1'h0;
      a2_s1_q  <= 1'h0;
      a2_q     <= 1'h0;
    end else begin
      lk_s1_q  <= pll_lock_in;
      lk_q     <= lk_s1_q;
      spi_s1_q <= ctl.spi_mode_m;
      spi_q    <= spi_s1_q;
      a1_s1_q  <= dev_address_bit1_pin;
      a1_q     <= a1_s1_q;
      a2_s1_q  <= dev_address_bit2_pin;
      a2_q     <= a2_s1_q;
    end
  end

  // device address bits follow the pins only in i2c mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      i2c_bits_q <= 2'h0;
    end else if (!spi_q) begin
      i2c_bits_q <= {a2_q, a1_q};
    end
  end

  // pll configuration registers, open before lock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pll_fb_q  <= `RPG_PLL_FB_RST;
      pll_pre_q <= `RPG_PLL_PRE_RST;
      pll_src_q <= `RPG_PLL_SRC_RST;
      pll_en_q  <= `RPG_PLL_EN_RST;
    end else if (wr_ok && ctl.sel_pll) begin
      if (acc_addr == `RPG_PLL_FB_ADDR) begin
        pll_fb_q <= acc_wdata;
      end else if (acc_addr == `RPG_PLL_PRE_ADDR) begin
        pll_pre_q <= acc_wdata;
      end else if (acc_addr == `RPG_PLL_SRC_ADDR) begin
        pll_src_q <= acc_wdata;
      end else if (acc_addr == `RPG_PLL_EN_ADDR) begin
        pll_en_q <= acc_wdata[0];
      end
    end
  end

  // power gating registers, writes dropped until lock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwr0_q <= `RPG_PWR0_RST;
      pwr1_q <= `RPG_PWR1_RST;
    end else if (wr_ok) begin
      if (ctl.sel_pwr0) begin
        pwr0_q <= acc_wdata[`RPG_PWR0_W-1:0];
      end else if (ctl.sel_pwr1) begin
        pwr1_q <= acc_wdata[`RPG_PWR1_W-1:0];
      end
    end
  end

  // one clock gate per block, all off until reset is released
  for (genvar i = 0; i < `RPG_BLK_W; i++) begin : g_gate
    logic bit_en;
    if (i < `RPG_PWR0_W) begin : g_p0
      assign bit_en = pwr0_q[i];
    end else begin : g_p1
      assign bit_en = pwr1_q[i-`RPG_PWR0_W];
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        blk_en_q[i] <= 1'h0;
      end else begin
        blk_en_q[i] <= bit_en && rdy_q;
      end
    end
  end

  // register read mux
  always_comb begin
    rd_mux = 16'h0000;
    if (acc_addr == `RPG_PLL_FB_ADDR) begin
      rd_mux = pll_fb_q;
    end else if (acc_addr == `RPG_PLL_PRE_ADDR) begin
      rd_mux = pll_pre_q;
    end else if (acc_addr == `RPG_PLL_SRC_ADDR) begin
      rd_mux = pll_src_q;
    end else if (acc_addr == `RPG_PLL_EN_ADDR) begin
      rd_mux = {15'h0000, pll_en_q};
    end else if (acc_addr == `RPG_PLL_LOCK_ADDR) begin
      rd_mux = {15'h0000, lk_q};
    end else if (acc_addr == `RPG_PWR0_ADDR) begin
      rd_mux = {9'h000, pwr0_q};
    end else if (acc_addr == `RPG_PWR1_ADDR) begin
      rd_mux = {12'h000, pwr1_q};
    end
  end

  // sequencer: registers answer next cycle, memory one cycle later
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= rpg_pkg::ST_IDLE;
      ack_q    <= 1'h0;
      ref_q    <= 1'h0;
      rdata_q  <= 16'h0000;
      mreq_q   <= 1'h0;                     // no clearing writes
      mwr_q    <= 1'h0;
      maddr_q  <= 16'h0000;
      mwdata_q <= 16'h0000;
    end else begin
      ack_q  <= 1'h0;
      ref_q  <= 1'h0;
      mreq_q <= 1'h0;
      case (st_q)
        rpg_pkg::ST_IDLE: begin
          if (take && !ctl.allow) begin
            ack_q   <= 1'h1;
            ref_q   <= 1'h1;
            rdata_q <= 16'h0000;
          end else if (take && ctl.sel_mem) begin
            mreq_q   <= 1'h1;
            mwr_q    <= acc_write;
            maddr_q  <= acc_addr;
            mwdata_q <= acc_wdata;
            st_q     <= rpg_pkg::ST_MEM;
          end else if (take) begin
            ack_q   <= 1'h1;
            rdata_q <= acc_write ? 16'h0000 : rd_mux;
          end
        end
        rpg_pkg::ST_MEM: begin
          ack_q   <= 1'h1;
          rdata_q <= mwr_q ? 16'h0000 : mem_rdata;
          st_q    <= rpg_pkg::ST_IDLE;
        end
        default: begin
          st_q <= rpg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // outputs, each straight from a flip-flop
  assign acc_ack       = ack_q;
  assign acc_refused   = ref_q;
  assign acc_rdata     = rdata_q;
  assign mem_req       = mreq_q;
  assign mem_write     = mwr_q;
  assign mem_addr      = maddr_q;
  assign mem_wdata     = mwdata_q;
  assign blk_en        = blk_en_q;
  assign pll_fb_div    = pll_fb_q;
  assign pll_pre_div   = pll_pre_q;
  assign pll_src       = pll_src_q;
  assign pll_enable    = pll_en_q;
  assign spi_mode      = spi_q;
  assign i2c_addr_bits = i2c_bits_q;
  assign ready         = rdy_q;

  // checks
  blk_off_unready_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) !rdy_q |=> blk_en_q == '0)
    else $error("block enabled before reset release");
  ready_no_pulse_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) arst_n && !rdy_q |-> ##[1:2] rdy_q)
    else $error("reset release not complete");
  gate_follows_reg_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) rdy_q |=>
      blk_en_q == {$past(pwr1_q), $past(pwr0_q)})
    else $error("clock gate does not follow register");
  no_mem_unlocked_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) take && ctl.sel_mem && !lk_q |=> !mreq_q)
    else $error("memory reached before lock");
  refused_zero_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) ref_q |-> ack_q && rdata_q == 16'h0000)
    else $error("refused access returned data");
  pwr_write_blocked_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) take && acc_write && !lk_q && !ctl.sel_pll
      |=> $stable(pwr0_q) && $stable(pwr1_q))
    else $error("power register written before lock");
  mem_answer_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) mreq_q |=> ack_q && !ref_q)
    else $error("memory access not answered");
  pll_write_open_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) take && acc_write &&
      acc_addr == `RPG_PLL_FB_ADDR |=> pll_fb_q == $past(acc_wdata))
    else $error("pll register write lost");
  i2c_bits_hold_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n) spi_q && $past(spi_q) |-> $stable(i2c_bits_q))
    else $error("address bits moved in spi mode");

  refused_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ref_q);
  mem_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    mreq_q && lk_q);
  gate_off_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    rdy_q && blk_en_q != '1);

endmodule : reset_power_gating_port_mode

// *** sim/host_model.sv ***
// host model that drives the slave select pin on the master clock
`timescale 1ns/10ps
module host_model (
  // master clock from the bench
  input  wire logic master_clock_input,
  // slave select / address bit 1 pin, idles high
  output      logic ss_pin_o
);
  initial ss_pin_o = 1'b1;

  // one select pulse: low for n_low master clocks, then high three
  task automatic pulse(input int n_low);
    @(posedge master_clock_input);
    ss_pin_o <= 1'b0;
    repeat (n_low) @(posedge master_clock_input);
    ss_pin_o <= 1'b1;
    repeat (3) @(posedge master_clock_input);
  endtask : pulse

  // steady pin level, used as an address bit in i2c mode
  task automatic set_level(input logic v);
    @(posedge master_clock_input);
    ss_pin_o <= v;
    repeat (3) @(posedge master_clock_input);
  endtask : set_level
endmodule : host_model

// *** sim/tb.sv ***
// self-checking bench for reset, power gating and port mode
`timescale 1ns/10ps
`include "rpg_defines.svh"
module tb;
  // clocks, reset, pins
  logic                  clk_sys              = 1'b0;
  logic                  arst_n               = 1'b0;
  logic                  master_clock_input   = 1'b0;
  logic                  ss_pin;
  logic                  dev_address_bit2_pin = 1'b0;
  logic                  pll_lock_in          = 1'b0;
  // access port
  logic                  acc_req              = 1'b0;
  logic                  acc_write            = 1'b0;
  rpg_pkg::word_t        acc_addr             = 16'h0000;
  rpg_pkg::word_t        acc_wdata            = 16'h0000;
  logic                  acc_ack, acc_refused, mem_req, mem_write;
  rpg_pkg::word_t        acc_rdata, mem_addr, mem_wdata;
  rpg_pkg::word_t        mem_rdata            = 16'h0000;
  // outputs
  logic [`RPG_BLK_W-1:0] blk_en;
  rpg_pkg::word_t        pll_fb_div, pll_pre_div, pll_src;
  logic                  pll_enable, spi_mode, ready;
  logic [1:0]            i2c_addr_bits;
  // behavioural model state
  rpg_pkg::word_t        pll_m [4];
  logic [6:0]            pwr0_m;
  logic [3:0]            pwr1_m;
  rpg_pkg::word_t        mem_m [int];
  logic                  locked_m = 1'b0;
  rpg_pkg::word_t        a, d;
  int                    n_mismatch = 0;
  int                    num_checks = 0;
  int                    cycles     = 0;
  integer                seed;

  // system clock and an unrelated master clock
  always #5 clk_sys = ~clk_sys;
  initial begin
    #2.3;
    forever #7.5 master_clock_input = ~master_clock_input;
  end

  reset_power_gating_port_mode u_reset_power_gating_port_mode (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .master_clock_input(master_clock_input),
    .dev_address_bit1_pin(ss_pin),
    .dev_address_bit2_pin(dev_address_bit2_pin),
    .pll_lock_in(pll_lock_in), .acc_req(acc_req),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_ack(acc_ack), .acc_refused(acc_refused),
    .acc_rdata(acc_rdata), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .blk_en(blk_en), .pll_fb_div(pll_fb_div), .pll_pre_div(pll_pre_div),
    .pll_src(pll_src), .pll_enable(pll_enable), .spi_mode(spi_mode),
    .i2c_addr_bits(i2c_addr_bits), .ready(ready)
  );

  host_model u_host_model (
    .master_clock_input(master_clock_input),
    .ss_pin_o(ss_pin)
  );

  // verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // compare one result against the model
  task automatic chk(input rpg_pkg::word_t got, input rpg_pkg::word_t exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // model read of one address
  function automatic rpg_pkg::word_t model_rd(input rpg_pkg::word_t ad);
    case (ad)
      16'hF000, 16'hF001, 16'hF002: return pll_m[ad[1:0]];
      16'hF003: return {15'h0000, pll_m[3][0]};
      16'hF004: return {15'h0000, locked_m};
      16'hF050: return {9'h000, pwr0_m};
      16'hF051: return {12'h000, pwr1_m};
      default:  return mem_m.exists(ad) ? mem_m[ad] : 16'h0000;
    endcase
  endfunction : model_rd

  // one slave port access, checked against the model
  task automatic acc(input logic wr, input rpg_pkg::word_t ad,
                     input rpg_pkg::word_t dw);
    logic           ack, seen, open, fwd;
    rpg_pkg::word_t erd;
    open = locked_m || (ad >= 16'hF000 && ad <= 16'hF004);
    fwd  = open && !(ad inside {[16'hF000:16'hF004], 16'hF050, 16'hF051});
    erd  = (wr || !open) ? 16'h0000 : model_rd(ad);
    ack  = 1'b0;
    seen = 1'b0;
    @(posedge clk_sys);
    acc_req   <= 1'b1;
    acc_write <= wr;
    acc_addr  <= ad;
    acc_wdata <= dw;
    if (fwd && !wr) mem_rdata <= erd;
    // request is taken at this edge; register answers stand right after it, memory answers one cycle later
    @(posedge clk_sys);
    acc_req <= 1'b0;
    for (int i = 0; i < 4 && !ack; i++) begin
      #1;
      if (mem_req === 1'b1) begin
        seen = 1'b1;
        chk(mem_addr, ad);
        chk(16'(mem_write), 16'(wr));
        if (wr) chk(mem_wdata, dw);
      end
      ack = (acc_ack === 1'b1);
      if (!ack) @(posedge clk_sys);
    end
    chk(16'(ack), 16'h0001);
    chk(16'(acc_refused), 16'(!open));
    chk(acc_rdata, erd);
    chk(16'(seen), 16'(fwd));
    if (open && wr) begin
      case (ad)
        16'hF000, 16'hF001, 16'hF002, 16'hF003: pll_m[ad[1:0]] = dw;
        16'hF004: ;
        16'hF050: pwr0_m = dw[6:0];
        16'hF051: pwr1_m = dw[3:0];
        default:  mem_m[ad] = dw;
      endcase
    end
  endtask : acc

  // block enables and pll outputs against the model
  task automatic check_outs();
    @(posedge clk_sys);
    #1;
    chk(16'(blk_en), {5'h00, pwr1_m, pwr0_m});
    chk(pll_fb_div, pll_m[0]);
    chk(pll_pre_div, pll_m[1]);
    chk(pll_src, pll_m[2]);
    chk(16'(pll_enable), 16'(pll_m[3][0]));
  endtask : check_outs

  // reset pulse of eleven cycles, then defaults
  task automatic do_reset();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    chk(16'(blk_en), 16'h0000);
    chk(16'(ready), 16'h0000);
    pll_m  = '{default: 16'h0000};
    pwr0_m = 7'h7F;
    pwr1_m = 4'hF;
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(16'(ready), 16'h0001);
    check_outs();
    chk(16'(spi_mode), 16'h0000);
  endtask : do_reset

  // main sequence
  initial begin
    seed = 32'hB75E;
    do_reset();
    // device address bits from the pins
    for (int k = 0; k < 4; k++) begin
      u_host_model.set_level(k[0]);
      @(posedge clk_sys);
      dev_address_bit2_pin <= k[1];
      repeat (6) @(posedge clk_sys);
      #1;
      chk(16'(i2c_addr_bits), 16'(k[1:0]));
    end
    // the address pin toggles above count as select pulses: clear them
    do_reset();
    // before lock only the pll registers are open, the rest are refused
    acc(1'b1, 16'hF050, 16'h0000);
    acc(1'b0, 16'hF050, 16'h0000);
    acc(1'b1, 16'h1234, 16'h5A5A);
    acc(1'b0, 16'hF0A0, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      a = 16'hF000 + 16'(k);
      if (k < 4) acc(1'b1, a, 16'($random(seed)));
      acc(1'b0, a, 16'h0000);
    end
    check_outs();
    // lock opens every register and memory
    @(posedge clk_sys);
    pll_lock_in <= 1'b1;
    locked_m = 1'b1;
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 16'hF004, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      a = k[0] ? 16'hF051 : 16'hF050;
      d = (k < 2) ? 16'h0000 : 16'($random(seed));
      acc(1'b1, a, d);
      acc(1'b0, a, 16'h0000);
      check_outs();
    end
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 16'hF0A0 : 16'($random(seed)) & 16'h7FFF;
      acc(1'b1, a, 16'($random(seed)));
      acc(1'b0, a, 16'h0000);
    end
    // two select pulses are not enough, the third selects spi
    u_host_model.pulse(2);
    u_host_model.pulse(2);
    repeat (30) @(posedge clk_sys);
    #1;
    chk(16'(spi_mode), 16'h0000);
    u_host_model.pulse(2);
    for (int i = 0; i < 40 && spi_mode !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(16'(spi_mode), 16'h0001);
    @(posedge clk_sys);
    dev_address_bit2_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(16'(i2c_addr_bits), 16'h0003);
    // second reset in mid-run returns to i2c and defaults
    @(posedge clk_sys);
    pll_lock_in <= 1'b0;
    locked_m = 1'b0;
    do_reset();
    acc(1'b0, 16'hF000, 16'h0000);
    acc(1'b0, 16'hF050, 16'h0000);
    final_report();
  end
endmodule : tb
